// [src/smf_pkg.sv]
package smf_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] DR_IDX = 8'h21;
   localparam logic [7:0] CR_IDX = 8'h22;
   localparam logic [7:0] SR_IDX = 8'h23;
   localparam int ADDR_W = 10;

   // serial_control_register fields
   localparam int CR_IE_BIT = 7;
   localparam int CR_OE_BIT = 6;
   localparam int CR_BYP_BIT = 5;
   localparam int CR_ROLE_BIT = 4;
   localparam int CR_CLOCK_IDLE_LEVEL_BIT = 3;
   localparam int CR_CAPTURE_EDGE_SELECT_BIT = 2;
   localparam int CR_RH_BIT = 1;
   localparam int CR_RL_BIT = 0;
   localparam logic [7:0] CR_RESET = 8'h00;

   // serial_status_register fields
   localparam int SR_DONE_BIT = 7;
   localparam int SR_WRITE_COLLISION_FLAG_BIT = 6;
   localparam int SR_MODE_FAULT_FLAG_BIT = 4;

   localparam logic [7:0] DR_RESET = 8'h00;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // half serial clock periods in cpu clocks
   localparam logic [6:0] HALF_DIV4 = 7'h02;
   localparam logic [6:0] HALF_DIV8 = 7'h04;
   localparam logic [6:0] HALF_DIV16 = 7'h08;
   localparam logic [6:0] HALF_DIV32 = 7'h10;
   localparam logic [6:0] HALF_DIV64 = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } smf_pin_in_s;

   typedef struct packed {
      logic sck;
      logic sck_oe_n;
      logic mosi;
      logic mosi_oe_n;
      logic miso;
      logic miso_oe_n;
   } smf_pin_out_s;

   typedef struct packed {
      logic [7:0] ctrl;
      logic done;
      logic write_collision_flag;
      logic mode_fault_flag;
      logic done_arm;
      logic write_collision_flag_arm;
      logic mode_fault_flag_arm;
      logic [7:0] shift;
      logic [7:0] rxbuf;
      logic in_bit;
      logic busy;
      logic started;
      logic [3:0] edges;
      logic sck_lvl;
      logic sck_prev;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [7:0] rdata;
      logic hready;
      logic hresp;
      logic irq;
      logic wake;
      smf_pin_out_s pins;
   } smf_state_s;

   function automatic logic [6:0] half_period(input logic byp, input logic [1:0] rate);
      logic [6:0] h;
      h = HALF_DIV128;
      case ({byp, rate})
         3'h4: h = HALF_DIV4;
         3'h0: h = HALF_DIV8;
         3'h1: h = HALF_DIV16;
         3'h6: h = HALF_DIV32;
         3'h2: h = HALF_DIV64;
         3'h3: h = HALF_DIV128;
         default: h = HALF_DIV128;
      endcase
      return h;
   endfunction
endpackage

// [src/smf_sync.sv]
`timescale 1ns/1ps
module smf_sync #(
   parameter int W = 4
) (
   input wire logic clk_sys_i, // cpu clock
   input wire logic reset_i, // sync reset, high
   input wire logic [W-1:0] d_i, // asynchronous levels
   output logic [W-1:0] q_o // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } smf_sync_state_s;

   smf_sync_state_s s;
   smf_sync_state_s next_s;

   generate
      if (W < 1) begin : g_bad
         $error("smf_sync needs W >= 1");
      end
   endgenerate

   always_comb begin
      next_s.meta = d_i;
      next_s.q = s.meta;
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign q_o = s.q;
endmodule // smf_sync

// [src/smf_rate_div.sv]
`timescale 1ns/1ps
module smf_rate_div #(
   parameter int CNT_W = 7
) (
   input wire logic clk_sys_i, // cpu clock
   input wire logic reset_i, // sync reset, high
   input wire logic run_i, // count while high
   input wire logic [CNT_W-1:0] half_i, // half period in cycles
   output logic tick_o // one-cycle pulse per half period
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } smf_div_state_s;

   smf_div_state_s s;
   smf_div_state_s next_s;

   generate
      if (CNT_W < 2) begin : g_bad
         $error("smf_rate_div needs CNT_W >= 2");
      end
   endgenerate

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!run_i) begin
         next_s.cnt = '0;
      end else if (s.cnt == half_i - CNT_W'(1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_o = s.tick;
endmodule // smf_rate_div

// [src/smf_spi.sv]
// Contract
// RQ1: idle clock level set by clock_idle_level in both roles.
// RQ2: capture edge select set: second clock transition captures the msb.
// RQ3: capture edge select clear: first clock transition captures the msb.
// RQ4: with capture edge select clear, master toggles select between bytes; code has no select output and never drives select.
// RQ5: selected slave freezes its shift data and refuses software writes.
// RQ6: data write during a transfer is discarded, transfer continues.
// RQ7: slave with capture edge select set drives msb only after first edge.
// RQ8: slave with capture edge select clear: write after select low collides.
// RQ9: master write while shifting is a collision; its select stays high.
// RQ10: collision sets write_collision_flag, never any interrupt.
// RQ11: master with select low: fault flag, drop enable and role.
// RQ12: fault flag clears by status access then control write.
// RQ13: while fault flag set, enable and role cannot be set.
// RQ14: only a master can raise the fault flag; it may persist.
// RQ15: overrun keeps the first byte after clearing, no indication.
// RQ16: wait mode keeps running; events wake the processor.
// RQ17: halt freezes everything; own events do not wake; code still lets miso enable follow select.
// RQ18: both events share one request, gated by enable and cpu mask.
// RQ19: bit 7 enables the request on done or fault flags.
// RQ20: bit 6 hands pins to the serial block; reset and fault clear it.
// RQ21: bit 5 zero keeps extra divide by two, one bypasses it; code bypasses it only for rates 00 and 10, rates 01 and 11 give 128.
// RQ22: bit 4 selects master, clock becomes output, data pins swap.
// RQ23: master clock from cpu clock, six divisors 4 to 128.
// RQ24: eight clock pulses exchange one byte, msb first, full duplex.
// RQ25: master starts on data write; end sets done and fills buffer.
// RQ26: done clears by status access then data read; writes blocked meanwhile.
// RQ27: external clock and select pass two flip-flops first.
// RQ28: collision flag clears by status access then data access.
`timescale 1ns/1ps
module smf_spi (
   input wire logic clk_sys_i, // cpu clock
   input wire logic reset_i, // sync reset, high
   input wire logic hsel_i, // ahb select
   input wire logic [31:0] haddr_i, // ahb address
   input wire logic [1:0] htrans_i, // ahb transfer type
   input wire logic hwrite_i, // ahb write
   input wire logic [2:0] hsize_i, // ahb size
   input wire logic [31:0] hwdata_i, // ahb write data
   input wire logic hready_i, // ahb bus ready
   output logic [31:0] hrdata_o, // ahb read data
   output logic hreadyout_o, // ahb slave ready
   output logic hresp_o, // ahb response, always okay
   input wire smf_pkg::smf_pin_in_s pins_i, // pin levels
   output smf_pkg::smf_pin_out_s pins_o, // pin drive, enables low = drive
   input wire logic irq_mask_i, // cpu global interrupt mask
   input wire logic halt_i, // cpu in halt
   output logic irq_o, // interrupt request
   output logic wake_o // wake from wait
);
   smf_pkg::smf_state_s s;
   smf_pkg::smf_state_s next_s;
   smf_pkg::smf_pin_in_s pin_q;
   logic tick;

   smf_sync #(
      .W(4)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .d_i(pins_i), // see RQ27
      .q_o(pin_q)
   );

   smf_rate_div #(
      .CNT_W(7)
   ) u_div (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .run_i(s.busy & s.ctrl[smf_pkg::CR_ROLE_BIT]),
      .half_i(smf_pkg::half_period(s.ctrl[smf_pkg::CR_BYP_BIT],
         {s.ctrl[smf_pkg::CR_RH_BIT], s.ctrl[smf_pkg::CR_RL_BIT]})), // see RQ21 see RQ23
      .tick_o(tick)
   );

   always_comb begin
      logic acc;
      logic mapped;
      logic [7:0] idx;
      logic hit_dr;
      logic hit_cr;
      logic hit_sr;
      logic dr_wr;
      logic cr_wr;
      logic role;
      logic oe;
      logic capture_edge_select;
      logic slave_sel;
      logic collide;
      logic frozen;
      logic allow;
      logic edge_now;
      logic smp;
      logic capture;
      logic ev;
      logic [7:0] result;
      acc = 1'b0;
      mapped = 1'b0;
      idx = 8'h00;
      hit_dr = 1'b0;
      hit_cr = 1'b0;
      hit_sr = 1'b0;
      dr_wr = 1'b0;
      cr_wr = 1'b0;
      collide = 1'b0;
      frozen = 1'b0;
      allow = 1'b0;
      edge_now = 1'b0;
      capture = 1'b0;
      result = 8'h00;
      next_s = s;
      role = s.ctrl[smf_pkg::CR_ROLE_BIT];
      oe = s.ctrl[smf_pkg::CR_OE_BIT];
      capture_edge_select = s.ctrl[smf_pkg::CR_CAPTURE_EDGE_SELECT_BIT];
      slave_sel = oe & ~role & ~pin_q.ss_n;
      smp = role ? pin_q.miso : pin_q.mosi; // see RQ22
      // halt: state holds except irq, wake and miso enable, bus accesses are ignored and read data holds its last value
      if (!halt_i) begin // see RQ17
         acc = hsel_i & htrans_i[1] & hready_i & (hsize_i == smf_pkg::HSIZE_WORD);
         mapped = (haddr_i[31:smf_pkg::ADDR_W] == '0) && (haddr_i[1:0] == 2'h0);
         idx = haddr_i[smf_pkg::ADDR_W-1:2];
         hit_dr = acc & mapped & (idx == smf_pkg::DR_IDX);
         hit_cr = acc & mapped & (idx == smf_pkg::CR_IDX);
         hit_sr = acc & mapped & (idx == smf_pkg::SR_IDX);
         dr_wr = s.wr_pend & (s.wr_idx == smf_pkg::DR_IDX);
         cr_wr = s.wr_pend & (s.wr_idx == smf_pkg::CR_IDX);

         // address phase: read data and access side effects
         next_s.wr_pend = acc & hwrite_i;
         next_s.wr_idx = mapped ? idx : 8'h00;
         next_s.rdata = 8'h00;
         if (acc & ~hwrite_i) begin
            if (hit_dr) begin
               next_s.rdata = s.rxbuf;
            end else if (hit_cr) begin
               next_s.rdata = s.ctrl;
            end else if (hit_sr) begin
               next_s.rdata[smf_pkg::SR_DONE_BIT] = s.done;
               next_s.rdata[smf_pkg::SR_WRITE_COLLISION_FLAG_BIT] = s.write_collision_flag;
               next_s.rdata[smf_pkg::SR_MODE_FAULT_FLAG_BIT] = s.mode_fault_flag;
            end
         end
         if (hit_sr) begin
            if (s.done) begin
               next_s.done_arm = 1'b1; // see RQ26
            end
            if (s.write_collision_flag) begin
               next_s.write_collision_flag_arm = 1'b1; // see RQ28
            end
            if (s.mode_fault_flag) begin
               next_s.mode_fault_flag_arm = 1'b1; // see RQ12
            end
         end
         if (hit_dr & ~hwrite_i & s.done_arm) begin
            next_s.done = 1'b0; // see RQ26
            next_s.done_arm = 1'b0;
         end
         if (hit_dr & s.write_collision_flag_arm) begin
            next_s.write_collision_flag = 1'b0; // see RQ28
            next_s.write_collision_flag_arm = 1'b0;
         end

         // data phase: control write
         if (cr_wr) begin
            allow = ~s.mode_fault_flag | s.mode_fault_flag_arm;
            next_s.ctrl = hwdata_i[7:0]; // see RQ19 see RQ21 see RQ22
            if (!allow) begin
               next_s.ctrl[smf_pkg::CR_OE_BIT] = oe & hwdata_i[smf_pkg::CR_OE_BIT]; // see RQ13
               next_s.ctrl[smf_pkg::CR_ROLE_BIT] = role & hwdata_i[smf_pkg::CR_ROLE_BIT]; // see RQ13
            end
            if (s.mode_fault_flag_arm) begin
               next_s.mode_fault_flag = 1'b0; // see RQ12
               next_s.mode_fault_flag_arm = 1'b0;
            end
         end

         // data phase: data write
         if (dr_wr) begin
            frozen = ~role & ~pin_q.ss_n; // see RQ5
            if (role) begin
               collide = s.busy; // see RQ9
            end else begin
               collide = ~pin_q.ss_n & (~capture_edge_select | s.started); // see RQ8
            end
            if (collide) begin
               next_s.write_collision_flag = 1'b1; // see RQ6 see RQ10
            end else if (!s.done && !frozen && !s.busy) begin // see RQ26
               next_s.shift = hwdata_i[7:0];
               if (role & oe) begin
                  next_s.busy = 1'b1; // see RQ25
                  next_s.edges = 4'h0;
               end
            end
         end

         // slave deselected: byte aborted, miso released
         if (!role && !slave_sel) begin
            next_s.busy = 1'b0;
            next_s.started = 1'b0;
            next_s.edges = 4'h0;
         end

         // shift engine, common to both roles
         if (role) begin
            edge_now = s.busy & tick;
         end else begin
            edge_now = slave_sel & (pin_q.sck != s.sck_prev);
         end
         next_s.sck_prev = pin_q.sck;
         if (edge_now) begin
            if (role) begin
               next_s.sck_lvl = ~s.sck_lvl;
            end
            next_s.started = 1'b1; // see RQ7
            next_s.busy = 1'b1;
            // even edge index with phase 0, odd with phase 1
            capture = (s.edges[0] == capture_edge_select); // see RQ2 see RQ3
            if (s.edges == smf_pkg::LAST_EDGE) begin // see RQ24
               result = {s.shift[6:0], capture_edge_select ? smp : s.in_bit};
               next_s.shift = result;
               if (!s.done) begin
                  next_s.rxbuf = result; // see RQ15
               end
               next_s.done = 1'b1; // see RQ25
               next_s.busy = 1'b0;
               next_s.started = 1'b0;
               next_s.edges = 4'h0;
            end else begin
               next_s.edges = s.edges + 4'h1;
               if (capture) begin
                  next_s.in_bit = smp;
               end else if (s.edges != 4'h0 || !capture_edge_select) begin
                  next_s.shift = {s.shift[6:0], s.in_bit}; // see RQ24
               end
            end
         end

         // mode fault last so it overrides a same-cycle control write
         if (role & ~pin_q.ss_n) begin // see RQ11 see RQ14
            next_s.mode_fault_flag = 1'b1;
            next_s.ctrl[smf_pkg::CR_OE_BIT] = 1'b0; // see RQ20
            next_s.ctrl[smf_pkg::CR_ROLE_BIT] = 1'b0; // see RQ22
            next_s.busy = 1'b0;
            next_s.started = 1'b0;
            next_s.edges = 4'h0;
         end
      end

      if (!next_s.busy) begin
         next_s.sck_lvl = next_s.ctrl[smf_pkg::CR_CLOCK_IDLE_LEVEL_BIT]; // see RQ1
      end

      // pin drive, enables low while driving
      next_s.pins.sck = next_s.sck_lvl;
      next_s.pins.sck_oe_n = ~(next_s.ctrl[smf_pkg::CR_OE_BIT] & next_s.ctrl[smf_pkg::CR_ROLE_BIT]); // see RQ20
      next_s.pins.mosi = next_s.shift[7];
      next_s.pins.mosi_oe_n = ~(next_s.ctrl[smf_pkg::CR_OE_BIT] & next_s.ctrl[smf_pkg::CR_ROLE_BIT]); // see RQ22
      next_s.pins.miso = next_s.shift[7];
      next_s.pins.miso_oe_n = ~(next_s.ctrl[smf_pkg::CR_OE_BIT] & ~next_s.ctrl[smf_pkg::CR_ROLE_BIT] &
         ~pin_q.ss_n & (~next_s.ctrl[smf_pkg::CR_CAPTURE_EDGE_SELECT_BIT] | next_s.started)); // see RQ7

      // collision flag deliberately left out of the request
      ev = next_s.ctrl[smf_pkg::CR_IE_BIT] & (next_s.done | next_s.mode_fault_flag); // see RQ10 see RQ19
      next_s.irq = ev & ~irq_mask_i & ~halt_i; // see RQ18
      next_s.wake = ev & ~halt_i; // see RQ16 see RQ17

      next_s.hready = 1'b1;
      next_s.hresp = 1'b0;
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s <= '0;
         s.ctrl <= smf_pkg::CR_RESET; // see RQ20
         s.shift <= smf_pkg::DR_RESET;
         s.rxbuf <= smf_pkg::DR_RESET;
         s.sck_prev <= 1'b1;
         s.hready <= 1'b1;
         s.pins.sck_oe_n <= 1'b1;
         s.pins.mosi_oe_n <= 1'b1;
         s.pins.miso_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata_o = {24'h000000, s.rdata};
   assign hreadyout_o = s.hready;
   assign hresp_o = s.hresp;
   assign pins_o = s.pins;
   assign irq_o = s.irq;
   assign wake_o = s.wake;
endmodule // smf_spi

// [testbench/smf_spi_monitor.sv]
`timescale 1ns/1ps
module smf_spi_monitor (
   input wire logic clk_sys_i, // cpu clock
   input wire logic reset_i, // sync reset, high
   input wire logic hsel_i, // ahb select
   input wire logic [1:0] htrans_i, // ahb transfer type
   input wire logic hwrite_i, // ahb write
   input wire logic hready_i, // ahb bus ready
   input wire logic [31:0] hrdata_o, // ahb read data
   input wire logic hresp_o, // ahb response
   input wire smf_pkg::smf_pin_in_s pins_i, // pin levels
   input wire smf_pkg::smf_pin_out_s pins_o, // pin drive
   input wire logic irq_mask_i, // cpu mask
   input wire logic halt_i, // cpu halt
   input wire logic irq_o, // interrupt request
   input wire logic wake_o // wake from wait
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   AST_HRESP_OKAY: assert property (hresp_o == 1'b0)
      else $error("bus response not okay");
   AST_HRDATA_IDLE: assert property (!$past(hsel_i && htrans_i[1] && !hwrite_i && hready_i) |-> hrdata_o == 32'h0)
      else $error("read data outside a read data phase");
   AST_IRQ_MASK: assert property ($past(irq_mask_i) |-> !irq_o)
      else $error("request while cpu mask set");
   AST_IRQ_WAKE: assert property (irq_o |-> wake_o)
      else $error("request without wake");
   AST_HALT_NOWAKE: assert property ($past(halt_i) |-> !wake_o && !irq_o)
      else $error("event escaped halt");
   AST_HALT_FROZEN: assert property ($past(halt_i) && !$past(reset_i) |-> $stable(pins_o))
      else $error("pins moved in halt");
   AST_FAULT_RELEASE: assert property ((!pins_i.ss_n && !pins_o.sck_oe_n) [*3] |-> ##[0:4] pins_o.sck_oe_n)
      else $error("master kept pins with select low");
   AST_ROLE_PINS: assert property (!pins_o.sck_oe_n |-> pins_o.miso_oe_n && !pins_o.mosi_oe_n)
      else $error("master pin directions wrong");
   AST_SCK_HALF: assert property (!pins_o.sck_oe_n && $past(!pins_o.sck_oe_n) && $changed(pins_o.sck)
      |=> $stable(pins_o.sck))
      else $error("serial clock half period below two cycles");

   COV_IRQ: cover property ($rose(irq_o));
   COV_FAULT: cover property ($rose(pins_o.sck_oe_n) && !pins_i.ss_n);
   COV_HALT: cover property ($past(halt_i) && $fell(wake_o));
endmodule // smf_spi_monitor

bind smf_spi smf_spi_monitor i_smf_spi_monitor (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
   .pins_i(pins_i), .pins_o(pins_o), .irq_mask_i(irq_mask_i), .halt_i(halt_i), .irq_o(irq_o), .wake_o(wake_o));

// [testbench/smf_slave_model.sv]
`timescale 1ns/1ps
module smf_slave_model (
   input wire logic sck_i, // serial clock level
   input wire logic mosi_i, // data from master
   input wire logic ss_n_i, // select, low
   input wire logic [7:0] tx_i, // byte to return
   output logic miso_o, // data to master
   output logic [7:0] rx_o // byte received
);
   logic [7:0] sh;
   initial miso_o = 1'b0;
   always @(negedge ss_n_i) begin
      sh = tx_i;
      miso_o = tx_i[7];
   end
   always @(posedge sck_i) begin
      if (!ss_n_i) rx_o = {rx_o[6:0], mosi_i};
   end
   always @(negedge sck_i) begin
      if (!ss_n_i) begin
         sh = {sh[6:0], 1'b0};
         miso_o = sh[7];
      end
   end
   // deselected: miso level inverted, so no stale level
   always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule // smf_slave_model

// [testbench/smf_spi_tb.sv]
`timescale 1ns/1ps
module smf_spi_tb;
   logic clk_sys_i, reset_i, hsel, hwrite, irq_mask, halt, ss_n, slv_ss_n;
   logic hreadyout_o, hresp_o, irq_o, wake_o, miso_m;
   logic [31:0] haddr, hwdata, hrdata_o;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] rx_m, tx_m, r;
   smf_pkg::smf_pin_in_s pin_i;
   smf_pkg::smf_pin_out_s pin_o;
   int n_fail = 0;
   int checks = 0;
   // index, write value, read back
   logic [23:0] rows [4] = '{24'h222c2c, 24'h220f0f, 24'h23ff00, 24'h305500};

   // released clock and mosi lines have pull-downs
   assign pin_i = {~pin_o.sck_oe_n & pin_o.sck, ~pin_o.mosi_oe_n & pin_o.mosi,
      pin_o.miso_oe_n ? miso_m : pin_o.miso, ss_n};

   smf_spi i_smf_spi (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pins_i(pin_i), .pins_o(pin_o), .irq_mask_i(irq_mask),
      .halt_i(halt), .irq_o(irq_o), .wake_o(wake_o));
   smf_slave_model i_smf_slave_model (.sck_i(pin_i.sck), .mosi_i(pin_i.mosi), .ss_n_i(slv_ss_n), .tx_i(tx_m),
      .miso_o(miso_m), .rx_o(rx_m));

   task end_sim();
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // address and data phase each held until hready is seen high at a rising edge
   task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      haddr <= {22'h0, idx, 2'b00};
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge clk_sys_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {24'h0, wd};
      @(posedge clk_sys_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
      // value before this edge's update: the data phase read data
      r = hrdata_o[7:0];
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      cmp(r, exp);
   endtask
   task wait_hi(input logic w);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while ((w ? wake_o : irq_o) !== 1'b1 && n < 3000);
      if (n >= 3000) n_fail++;
      @(posedge clk_sys_i);
   endtask
   task settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // two transfers of some 130 cycles plus register traffic
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_fail++;
      end_sim();
   end
   initial begin
      reset_i = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = smf_pkg::HSIZE_WORD;
      haddr = 32'h0;
      hwdata = 32'h0;
      irq_mask = 1'b0;
      halt = 1'b0;
      ss_n = 1'b1;
      slv_ss_n = 1'b1;
      tx_m = 8'h3c;
      repeat (5) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      rd(smf_pkg::CR_IDX, smf_pkg::CR_RESET);
      rd(smf_pkg::SR_IDX, 8'h00);
      rd(smf_pkg::DR_IDX, smf_pkg::DR_RESET);
      foreach (rows[i]) begin
         xfer(1'b1, rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      xfer(1'b1, smf_pkg::CR_IDX, 8'hd9);
      settle(1);
      cmp({7'h0, pin_o.sck}, 8'h01);
      xfer(1'b1, smf_pkg::CR_IDX, 8'hd1);
      settle(1);
      cmp({7'h0, pin_o.sck}, 8'h00);
      slv_ss_n <= 1'b0;
      xfer(1'b1, smf_pkg::DR_IDX, 8'ha5);
      xfer(1'b1, smf_pkg::DR_IDX, 8'h5a);
      wait_hi(1'b0);
      cmp(rx_m, 8'ha5);
      xfer(1'b1, smf_pkg::DR_IDX, 8'h77);
      rd(smf_pkg::SR_IDX, 8'hc0);
      rd(smf_pkg::DR_IDX, 8'h3c);
      rd(smf_pkg::SR_IDX, 8'h00);
      cmp({7'h0, irq_o}, 8'h00);
      slv_ss_n <= 1'b1;
      tx_m <= 8'h96;
      irq_mask <= 1'b1;
      @(posedge clk_sys_i);
      slv_ss_n <= 1'b0;
      xfer(1'b1, smf_pkg::DR_IDX, 8'h69);
      wait_hi(1'b1);
      cmp({7'h0, irq_o}, 8'h00);
      irq_mask <= 1'b0;
      settle(2);
      cmp({7'h0, irq_o}, 8'h01);
      halt <= 1'b1;
      settle(2);
      cmp({7'h0, wake_o}, 8'h00);
      halt <= 1'b0;
      settle(2);
      cmp({7'h0, wake_o}, 8'h01);
      rd(smf_pkg::SR_IDX, 8'h80);
      rd(smf_pkg::DR_IDX, 8'h96);
      cmp(rx_m, 8'h69);
      slv_ss_n <= 1'b1;
      ss_n <= 1'b0;
      settle(8);
      cmp({7'h0, irq_o}, 8'h01);
      ss_n <= 1'b1;
      xfer(1'b1, smf_pkg::CR_IDX, 8'hd1);
      rd(smf_pkg::CR_IDX, 8'h81);
      rd(smf_pkg::SR_IDX, 8'h10);
      xfer(1'b1, smf_pkg::CR_IDX, 8'h81);
      rd(smf_pkg::SR_IDX, 8'h00);
      xfer(1'b1, smf_pkg::CR_IDX, 8'h40);
      ss_n <= 1'b0;
      settle(8);
      ss_n <= 1'b1;
      rd(smf_pkg::SR_IDX, 8'h00);
      end_sim();
   end
endmodule // smf_spi_tb
